// ==== design/stn_regs.vh ====
// register map, field positions, reset values and codes of the stn timing block
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef STN_REGS_VH
`define STN_REGS_VH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define STN_ADR_CTRL 8'h00
`define STN_ADR_SIZE 8'h04
`define STN_ADR_TIME 8'h08
`define STN_ADR_RED 8'h0C
`define STN_ADR_GREEN 8'h10
`define STN_ADR_BLUE 8'h14
`define STN_ADR_STAT 8'h18
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define STN_CTRL_EN 0
`define STN_CTRL_BIAS_TOGGLE_MODE 1
`define STN_CTRL_MODE 2
`define STN_CTRL_TYPE 5
`define STN_CTRL_CLK 16
`define STN_SIZE_HOZ 0
`define STN_SIZE_VERT 16
`define STN_TIME_WLH 0
`define STN_TIME_POST_LINE_DELAY 2
`define STN_TIME_BLANK 8
`define STN_TIME_BIAS_LINE_INTERVAL 16
`define STN_STAT_FSYNC 16
`define STN_STAT_BIAS 17
`define STN_STAT_UNDER 18
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define STN_CTRL_RST 32'h0002_0000
`define STN_SIZE_RST 32'h0000_0000
`define STN_TIME_RST 32'h0000_0000
`define STN_LUT_RST 32'h0000_0000
// ------------------------------------------------------------
// timing counts and codes
// ------------------------------------------------------------
`define STN_DIV_MIN 10'h002
`define STN_WORD_BITS 7'h20
`define STN_MODE_MONO 3'h0
`define STN_MODE_GRAY4 3'h1
`define STN_MODE_GRAY16 3'h2
`define STN_MODE_C256 3'h3
`define STN_MODE_C4096 3'h4
`define STN_TYPE_DUAL4 2'h0
`define STN_TYPE_SINGLE4 2'h1
`define STN_TYPE_SINGLE8 2'h2
`endif

// ==== design/stn_pix_map.v ====
// one output dot: level lookup and frame rate shading for one sub-pixel slot
// assumes the caller aligns the pixel bits msb-first in win_i
`timescale 1ns/1ns
`include "stn_regs.vh"
module stn_pix_map (
   input wire [2:0] mode_i,
   input wire [7:0] win_i,
   input wire [1:0] chan_i,
   input wire [31:0] red_i,
   input wire [31:0] green_i,
   input wire [15:0] blue_i,
   input wire [3:0] phase_i,
   output reg dot_o
);
   // ------------------------------------------------------------
   // lookup
   // ------------------------------------------------------------
   function [3:0] pick;
      input [31:0] t;
      input [2:0] i;
      begin
         pick = t[{i, 2'b00} +: 4];
      end
   endfunction

   reg [3:0] lvl;
   always @* begin
      lvl = 4'h0;
      case (mode_i)
         `STN_MODE_GRAY4: lvl = pick({16'h0000, blue_i}, {1'b0, win_i[7:6]});
         `STN_MODE_GRAY16: lvl = win_i[7:4];
         `STN_MODE_C256: begin
            if (chan_i == 2'h0)
               lvl = pick(red_i, win_i[7:5]);
            else if (chan_i == 2'h1)
               lvl = pick(green_i, win_i[4:2]);
            else
               lvl = pick({16'h0000, blue_i}, {1'b0, win_i[1:0]});
         end
         `STN_MODE_C4096: lvl = win_i[7:4];
         default: lvl = 4'h0;
      endcase
      // mono bypasses lookup and shading
      if (mode_i == `STN_MODE_MONO)
         dot_o = win_i[7];
      else
         dot_o = (lvl == 4'hF) | (lvl > phase_i);
   end
endmodule // stn_pix_map

// ==== design/stn_lcd_timing.v ====
// stn panel timing generator, pixel serializer and wishbone register set
// assumes line words arrive on valid/ready streams from the dma fifos, one clock
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/1ns
`include "stn_regs.vh"
module stn_lcd_timing #(
   parameter HOZ_W = 11,
   parameter VERT_W = 10
) (
   input wire clk_i,
   input wire rst_i,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   input wire wb_we_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   output wire [31:0] wb_dat_o,
   output wire wb_ack_o,
   input wire [31:0] upper_line_fifo_data_i,
   input wire upper_line_fifo_valid_i,
   output wire upper_line_fifo_ready_o,
   input wire [31:0] lower_line_fifo_data_i,
   input wire lower_line_fifo_valid_i,
   output wire lower_line_fifo_ready_o,
   output wire frame_sync_out_o,
   output wire line_sync_out_o,
   output wire pixel_clock_out_o,
   output wire ac_bias_out_o,
   output wire [15:0] pixel_data_out_o
);
   localparam [2:0] ST_OFF = 3'h0;
   localparam [2:0] ST_DATA = 3'h1;
   localparam [2:0] ST_PULSE = 3'h2;
   localparam [2:0] ST_DELAY = 3'h3;
   localparam [2:0] ST_BLANK = 3'h4;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function [31:0] bmask;
      input [3:0] sel;
      begin
         bmask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      end
   endfunction

   function [1:0] div3;
      input [3:0] s;
      begin
         div3 = (s >= 4'h9) ? 2'h3 : (s >= 4'h6) ? 2'h2 : (s >= 4'h3) ? 2'h1 : 2'h0;
      end
   endfunction

   function [1:0] mod3;
      input [3:0] s;
      reg [3:0] q;
      begin
         q = {2'b00, div3(s)};
         q = s - (q + q + q);
         mod3 = q[1:0];
      end
   endfunction

   // ------------------------------------------------------------
   // register set
   // ------------------------------------------------------------
   reg [31:0] ctrl_r;
   reg [31:0] size_r;
   reg [31:0] time_r;
   reg [31:0] red_r;
   reg [31:0] green_r;
   reg [15:0] blue_r;
   reg underrun_r;
   reg ack_r;
   reg [31:0] rdat_r;
   reg [31:0] rdat_nxt;

   wire en = ctrl_r[`STN_CTRL_EN];
   wire bias_toggle_mode = ctrl_r[`STN_CTRL_BIAS_TOGGLE_MODE];
   wire [2:0] mode = ctrl_r[`STN_CTRL_MODE +: 3];
   wire [1:0] dtype = ctrl_r[`STN_CTRL_TYPE +: 2];
   wire [9:0] clkdiv = ctrl_r[`STN_CTRL_CLK +: 10];
   wire [HOZ_W-1:0] hoz = size_r[`STN_SIZE_HOZ +: HOZ_W];
   wire [VERT_W-1:0] vert = size_r[`STN_SIZE_VERT +: VERT_W];
   wire [1:0] line_pulse_width = time_r[`STN_TIME_WLH +: 2];
   wire [1:0] post_line_delay = time_r[`STN_TIME_POST_LINE_DELAY +: 2];
   wire [7:0] lblank = time_r[`STN_TIME_BLANK +: 8];
   wire [7:0] bias_line_interval = time_r[`STN_TIME_BIAS_LINE_INTERVAL +: 8];

   wire wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
   wire wb_wr = wb_req & wb_we_i;
   wire [31:0] wm = bmask(wb_sel_i);
   wire [31:0] wv = wb_dat_i & wm;
   wire under_set;
   wire under_clr = wb_wr & (wb_adr_i == `STN_ADR_STAT) & wv[`STN_STAT_UNDER];

   reg [2:0] st_r;
   reg [9:0] div_r;
   reg [HOZ_W:0] shf_r;
   reg [10:0] tmr_r;
   reg [VERT_W-1:0] line_r;
   reg [7:0] mcnt_r;
   reg [3:0] fcnt_r;
   reg pixel_clock_out_r;
   reg lsync_r;
   reg fsync_r;
   reg bias_r;
   reg [15:0] pd_r;

   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= `STN_CTRL_RST;
         size_r <= `STN_SIZE_RST;
         time_r <= `STN_TIME_RST;
         red_r <= `STN_LUT_RST;
         green_r <= `STN_LUT_RST;
         blue_r <= 16'h0000;
         ack_r <= 1'b0;
         rdat_r <= 32'h0000_0000;
         underrun_r <= 1'b0;
      end else begin
         ack_r <= wb_req;
         if (wb_req)
            rdat_r <= rdat_nxt;
         if (wb_wr) begin
            case (wb_adr_i)
               `STN_ADR_CTRL: ctrl_r <= (ctrl_r & ~wm) | wv;
               `STN_ADR_SIZE: size_r <= (size_r & ~wm) | wv;
               `STN_ADR_TIME: time_r <= (time_r & ~wm) | wv;
               `STN_ADR_RED: red_r <= (red_r & ~wm) | wv;
               `STN_ADR_GREEN: green_r <= (green_r & ~wm) | wv;
               `STN_ADR_BLUE: blue_r <= (blue_r & ~wm[15:0]) | wv[15:0];
               default: ;
            endcase
         end
         // a new underrun in the clearing cycle keeps the flag
         if (under_set)
            underrun_r <= 1'b1;
         else if (under_clr)
            underrun_r <= 1'b0;
      end
   end

   always @* begin
      rdat_nxt = 32'h0000_0000;
      case (wb_adr_i)
         `STN_ADR_CTRL: rdat_nxt = ctrl_r;
         `STN_ADR_SIZE: rdat_nxt = size_r;
         `STN_ADR_TIME: rdat_nxt = time_r;
         `STN_ADR_RED: rdat_nxt = red_r;
         `STN_ADR_GREEN: rdat_nxt = green_r;
         `STN_ADR_BLUE: rdat_nxt = {16'h0000, blue_r};
         `STN_ADR_STAT: begin
            rdat_nxt[VERT_W-1:0] = line_r;
            rdat_nxt[`STN_STAT_FSYNC] = fsync_r;
            rdat_nxt[`STN_STAT_BIAS] = bias_r;
            rdat_nxt[`STN_STAT_UNDER] = underrun_r;
         end
         default: rdat_nxt = 32'h0000_0000;
      endcase
   end

   // ------------------------------------------------------------
   // timing generator
   // ------------------------------------------------------------
   // divider below the minimum is forced up rather than stalling the panel
   wire [9:0] divx = (clkdiv < `STN_DIV_MIN) ? `STN_DIV_MIN : clkdiv;
   wire div_end = (div_r == divx - 10'h001);
   wire shift_go = (st_r == ST_DATA) & div_end & ~pixel_clock_out_r;
   wire [HOZ_W:0] hozp1 = {1'b0, hoz} + {{HOZ_W{1'b0}}, 1'b1};
   wire data_done = (st_r == ST_DATA) & div_end & pixel_clock_out_r & (shf_r == hozp1);
   // a zero pulse width still gives one cycle so every line has its pulse
   wire [10:0] plen = (line_pulse_width == 2'h0) ? 11'h001 : {9'h000, line_pulse_width};
   wire [10:0] blen = {lblank, 3'b000};
   wire tmr0 = (tmr_r == 11'h000);
   wire enter_data = (st_r == ST_OFF) |
                     ((st_r == ST_PULSE) & tmr0 & (post_line_delay == 2'h0) & (lblank == 8'h00)) |
                     ((st_r == ST_DELAY) & tmr0 & (lblank == 8'h00)) |
                     ((st_r == ST_BLANK) & tmr0);
   wire [VERT_W-1:0] nline = ((st_r == ST_OFF) | (line_r == vert)) ?
                             {VERT_W{1'b0}} : line_r + {{(VERT_W-1){1'b0}}, 1'b1};
   wire frame_start = enter_data & (nline == {VERT_W{1'b0}});

   always @(posedge clk_i) begin
      if (rst_i | ~en) begin
         st_r <= ST_OFF;
         div_r <= 10'h000;
         shf_r <= {(HOZ_W+1){1'b0}};
         tmr_r <= 11'h000;
         line_r <= {VERT_W{1'b0}};
         mcnt_r <= 8'h00;
         fcnt_r <= 4'h0;
         pixel_clock_out_r <= 1'b0;
         lsync_r <= 1'b0;
         fsync_r <= 1'b0;
         bias_r <= 1'b0;
      end else begin
         case (st_r)
            ST_DATA: begin
               div_r <= div_end ? 10'h000 : div_r + 10'h001;
               if (div_end)
                  pixel_clock_out_r <= ~pixel_clock_out_r;
               if (shift_go)
                  shf_r <= shf_r + {{HOZ_W{1'b0}}, 1'b1};
               if (data_done) begin
                  st_r <= ST_PULSE;
                  tmr_r <= plen - 11'h001;
                  lsync_r <= 1'b1;
                  pixel_clock_out_r <= 1'b0;
                  if (bias_toggle_mode) begin
                     if ((bias_line_interval == 8'h00) | (mcnt_r + 8'h01 >= bias_line_interval)) begin
                        bias_r <= ~bias_r;
                        mcnt_r <= 8'h00;
                     end else begin
                        mcnt_r <= mcnt_r + 8'h01;
                     end
                  end
               end
            end
            ST_PULSE: begin
               if (tmr0) begin
                  lsync_r <= 1'b0;
                  if (post_line_delay != 2'h0) begin
                     st_r <= ST_DELAY;
                     tmr_r <= {9'h000, post_line_delay} - 11'h001;
                  end else if (lblank != 8'h00) begin
                     st_r <= ST_BLANK;
                     tmr_r <= blen - 11'h001;
                  end
               end else begin
                  tmr_r <= tmr_r - 11'h001;
               end
            end
            ST_DELAY: begin
               if (tmr0) begin
                  if (lblank != 8'h00) begin
                     st_r <= ST_BLANK;
                     tmr_r <= blen - 11'h001;
                  end
               end else begin
                  tmr_r <= tmr_r - 11'h001;
               end
            end
            ST_BLANK: begin
               if (~tmr0)
                  tmr_r <= tmr_r - 11'h001;
            end
            default: ;
         endcase
         if (enter_data) begin
            st_r <= ST_DATA;
            // full low half before the first rise keeps hoz+1 whole clocks per line
            div_r <= 10'h000;
            shf_r <= {(HOZ_W+1){1'b0}};
            pixel_clock_out_r <= 1'b0;
            line_r <= nline;
            fsync_r <= frame_start;
            if (frame_start) begin
               fcnt_r <= fcnt_r + 4'h1;
               if (~bias_toggle_mode)
                  bias_r <= ~bias_r;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // pixel streams
   // ------------------------------------------------------------
   wire [63:0] din_all = {lower_line_fifo_data_i, upper_line_fifo_data_i};
   wire [1:0] vld_all = {lower_line_fifo_valid_i, upper_line_fifo_valid_i};
   wire [1:0] rdy_w;
   wire [1:0] under_w;
   wire [15:0] dots_all;
   wire [1:0] wlog = (mode == `STN_MODE_MONO) ? 2'h0 : (mode == `STN_MODE_GRAY4) ? 2'h1 : 2'h2;
   wire is_c256 = (mode == `STN_MODE_C256);

   genvar g;
   genvar k;
   generate
      for (g = 0; g < 2; g = g + 1) begin : strm
         // the lower stream only runs for the dual scan panel half
         wire act = (g == 0) | (dtype == `STN_TYPE_DUAL4);
         wire [3:0] nslot = ((g == 0) & (dtype == `STN_TYPE_SINGLE8)) ? 4'h8 : 4'h4;
         reg [63:0] sr_r;
         reg [63:0] sr_nxt;
         reg [6:0] cnt_r;
         reg [6:0] cnt_nxt;
         reg [6:0] cnt1;
         reg [1:0] cb_r;
         reg rdy_r;
         wire [3:0] cbn = {2'b00, cb_r} + nslot;
         wire [6:0] used = is_c256 ? {2'b00, div3(cbn), 3'b000} : ({3'b000, nslot} << wlog);
         wire take = vld_all[g] & rdy_r;
         always @* begin
            sr_nxt = sr_r;
            cnt1 = cnt_r;
            if (shift_go & act) begin
               sr_nxt = sr_r << used;
               cnt1 = (cnt_r >= used) ? cnt_r - used : 7'h00;
            end
            cnt_nxt = cnt1;
            if (take) begin
               sr_nxt = sr_nxt | ({din_all[32*g +: 32], 32'h0000_0000} >> cnt1);
               cnt_nxt = cnt1 + `STN_WORD_BITS;
            end
         end
         always @(posedge clk_i) begin
            if (rst_i | ~en) begin
               sr_r <= 64'h0000_0000_0000_0000;
               cnt_r <= 7'h00;
               cb_r <= 2'h0;
               rdy_r <= 1'b0;
            end else begin
               sr_r <= sr_nxt;
               cnt_r <= cnt_nxt;
               rdy_r <= act & (cnt_nxt <= `STN_WORD_BITS);
               if (enter_data)
                  cb_r <= 2'h0;
               else if (shift_go & act & is_c256)
                  cb_r <= mod3(cbn);
            end
         end
         assign rdy_w[g] = rdy_r;
         assign under_w[g] = act & (cnt_r < used);
         for (k = 0; k < 8; k = k + 1) begin : slot
            localparam [3:0] KK = k;
            wire [3:0] s = {2'b00, cb_r} + KK;
            wire [5:0] off = is_c256 ? {1'b0, div3(s), 3'b000} : ({2'b00, KK} << wlog);
            wire [63:0] sh = sr_r << off;
            // shading phase walks with frame, line and slot to spread flicker
            wire [3:0] ph = fcnt_r + KK + line_r[3:0];
            stn_pix_map u_map (
               .mode_i(mode),
               .win_i(sh[63:56]),
               .chan_i(mod3(s)),
               .red_i(red_r),
               .green_i(green_r),
               .blue_i(blue_r),
               .phase_i(ph),
               .dot_o(dots_all[8*g + 7 - k])
            );
         end
      end
   endgenerate

   assign under_set = shift_go & (|under_w);

   always @(posedge clk_i) begin
      if (rst_i | ~en) begin
         pd_r <= 16'h0000;
      end else if (shift_go) begin
         case (dtype)
            `STN_TYPE_SINGLE8: pd_r <= {8'h00, dots_all[7:0]};
            `STN_TYPE_SINGLE4: pd_r <= {12'h000, dots_all[7:4]};
            default: pd_r <= {8'h00, dots_all[7:4], dots_all[15:12]};
         endcase
      end
   end

   assign wb_dat_o = rdat_r;
   assign wb_ack_o = ack_r;
   assign upper_line_fifo_ready_o = rdy_w[0];
   assign lower_line_fifo_ready_o = rdy_w[1];
   assign frame_sync_out_o = fsync_r;
   assign line_sync_out_o = lsync_r;
   assign pixel_clock_out_o = pixel_clock_out_r;
   assign ac_bias_out_o = bias_r;
   assign pixel_data_out_o = pd_r;
endmodule // stn_lcd_timing

// ==== tb/stn_lcd_timing_props.sv ====
// checker: bus handshake, panel timing and lane relations of the stn block
// assumes the control word is written with all byte enables set
`timescale 1ns/1ns
module stn_lcd_timing_props #(
   parameter HOZ_W = 11,
   parameter VERT_W = 10
) (
   input wire clk_i,
   input wire rst_i,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   input wire wb_we_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire lower_line_fifo_ready_o,
   input wire frame_sync_out_o,
   input wire line_sync_out_o,
   input wire pixel_clock_out_o,
   input wire ac_bias_out_o,
   input wire [15:0] pixel_data_out_o
);
   // ----------------------------------------
   // control mirror
   // ----------------------------------------
   reg en_r;
   reg mm_r;
   reg dual_r;
   reg [9:0] div_r;
   reg [9:0] hi_r;
   wire ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00
      && wb_sel_i == 4'hF;
   always @(posedge clk_i) begin
      if (rst_i) begin
         en_r <= 1'b0;
         mm_r <= 1'b0;
         dual_r <= 1'b1;
         div_r <= 10'h002;
      end else if (ctl_wr) begin
         en_r <= wb_dat_i[0];
         mm_r <= wb_dat_i[1];
         dual_r <= wb_dat_i[6:5] == 2'h0;
         // a divider under two still runs at two
         div_r <= (wb_dat_i[25:16] < 10'h002) ? 10'h002 : wb_dat_i[25:16];
      end
   end
   always @(posedge clk_i) begin
      if (rst_i || !pixel_clock_out_o)
         hi_r <= 10'h000;
      else
         hi_r <= hi_r + 10'h001;
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (rst_i || !en_r);
   AST_ACK_PULSE:
   assert property (disable iff (rst_i) wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   AST_ACK_ANSWER:
   assert property (disable iff (rst_i) wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   AST_FS_EDGE:
   assert property ($rose(frame_sync_out_o) || $fell(frame_sync_out_o) |->
      !pixel_clock_out_o && !line_sync_out_o ##1 !pixel_clock_out_o)
      else $error("frame sync edge off the line start");
   AST_FS_HOLD:
   assert property (frame_sync_out_o && line_sync_out_o |=>
      frame_sync_out_o || $fell(line_sync_out_o))
      else $error("frame sync dropped inside the first line");
   AST_LS_NO_PCLK:
   assert property (line_sync_out_o |-> !pixel_clock_out_o) else $error("clock in line pulse");
   AST_PCLK_HIGH:
   assert property ($fell(pixel_clock_out_o) |-> hi_r == div_r)
      else $error("pixel clock high time wrong");
   AST_BIAS_WHEN:
   assert property ($changed(ac_bias_out_o) |-> (mm_r ? line_sync_out_o : frame_sync_out_o))
      else $error("bias toggled at wrong moment");
   AST_DATA_ON_RISE:
   assert property ($changed(pixel_data_out_o) |-> $rose(pixel_clock_out_o))
      else $error("data moved off the clock rise");
   AST_DATA_UPPER:
   assert property (pixel_data_out_o[15:8] == 8'h00) else $error("unused lanes driven");
   AST_LOWER_IDLE:
   assert property (disable iff (rst_i) !en_r || !dual_r |=> !lower_line_fifo_ready_o)
      else $error("lower stream taken outside dual scan");
   cover property ($rose(frame_sync_out_o));
   cover property (mm_r && $changed(ac_bias_out_o));
   cover property (ctl_wr);
endmodule // stn_lcd_timing_props
bind stn_lcd_timing stn_lcd_timing_props #(.HOZ_W(HOZ_W), .VERT_W(VERT_W)) props_inst (
   .clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .lower_line_fifo_ready_o, .frame_sync_out_o, .line_sync_out_o,
   .pixel_clock_out_o, .ac_bias_out_o, .pixel_data_out_o);

// ==== tb/stn_panel_model.sv ====
// panel model: listens to the stn link and reports line and frame figures
// assumes the bus clock; the panel drives nothing back
`timescale 1ns/1ns
module stn_panel_model (
   input wire clk_i,
   input wire rst_i,
   input wire frame_sync_i,
   input wire line_sync_i,
   input wire pixel_clock_i,
   input wire ac_bias_i,
   input wire [15:0] pixel_data_i,
   output reg [15:0] shifts_o,
   output reg [15:0] period_o,
   output reg [15:0] lines_o,
   output reg [15:0] fs_len_o,
   output reg [15:0] ls_cnt_o,
   output reg [15:0] fs_cnt_o,
   output reg [15:0] flips_o,
   output reg [15:0] first_o
);
   reg pc_r, ls_r, fs_r, bias_r;
   reg [15:0] sh_r, per_r, ln_r, fl_r;
   // ----------------------------------------
   // capture
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         {pc_r, ls_r, fs_r, bias_r} <= 4'h0;
         {sh_r, per_r, ln_r, fl_r} <= 64'h0;
         {shifts_o, period_o, lines_o, fs_len_o} <= 64'h0;
         {ls_cnt_o, fs_cnt_o, flips_o, first_o} <= 64'h0;
      end else begin
         {pc_r, ls_r, fs_r, bias_r} <= {pixel_clock_i, line_sync_i, frame_sync_i, ac_bias_i};
         per_r <= per_r + 16'h0001;
         fl_r <= frame_sync_i ? fl_r + 16'h0001 : 16'h0000;
         if (ac_bias_i != bias_r)
            flips_o <= flips_o + 16'h0001;
         // data is fresh on the rising clock, so latch it there
         if (pixel_clock_i && !pc_r) begin
            sh_r <= sh_r + 16'h0001;
            if (sh_r == 16'h0000)
               first_o <= pixel_data_i;
         end
         if (line_sync_i && !ls_r) begin
            shifts_o <= sh_r;
            sh_r <= 16'h0000;
            period_o <= per_r;
            per_r <= 16'h0001;
            ln_r <= ln_r + 16'h0001;
            ls_cnt_o <= ls_cnt_o + 16'h0001;
         end
         if (frame_sync_i && !fs_r) begin
            lines_o <= ln_r;
            ln_r <= 16'h0000;
            fs_cnt_o <= fs_cnt_o + 16'h0001;
         end
         if (!frame_sync_i && fs_r)
            fs_len_o <= fl_r;
      end
   end
endmodule // stn_panel_model

// ==== tb/stn_lcd_timing_tb_top.sv ====
// bench top: drives bus and line streams, judges the link through the panel model
// assumes streams always offer a word; the panel model counts lines and frames
`timescale 1ns/1ns
`include "stn_regs.vh"
`define CHK(g, e) begin num_checks = num_checks + 1; if ((g) !== (e)) begin \
   fails = fails + 1; $display("Error at %0t: got %h exp %h", $time, (g), (e)); end end
module stn_lcd_timing_tb_top;
   reg clk_i, rst_i, cyc, stb, we;
   reg [7:0] adr;
   reg [31:0] wdat, rdat, up_d, lo_d;
   wire [31:0] dat_o;
   wire ack, fs, ls, pc, bias;
   wire [15:0] pd, shifts, period, lines, fs_len, ls_cnt, fs_cnt, flips, first_dot;
   integer fails, num_checks;
   stn_lcd_timing stn_lcd_timing_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .upper_line_fifo_data_i(up_d),
      .upper_line_fifo_valid_i(1'b1), .upper_line_fifo_ready_o(),
      .lower_line_fifo_data_i(lo_d), .lower_line_fifo_valid_i(1'b1),
      .lower_line_fifo_ready_o(), .frame_sync_out_o(fs), .line_sync_out_o(ls),
      .pixel_clock_out_o(pc), .ac_bias_out_o(bias), .pixel_data_out_o(pd));
   stn_panel_model stn_panel_model_inst (.clk_i(clk_i), .rst_i(rst_i), .frame_sync_i(fs),
      .line_sync_i(ls), .pixel_clock_i(pc), .ac_bias_i(bias), .pixel_data_i(pd),
      .shifts_o(shifts), .period_o(period), .lines_o(lines), .fs_len_o(fs_len),
      .ls_cnt_o(ls_cnt), .fs_cnt_o(fs_cnt), .flips_o(flips), .first_o(first_dot));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic wb(input bit w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         n = 0;
         {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
         @(posedge clk_i);
         while (ack !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n = n + 1;
         end
         if (n >= 100)
            fails = fails + 1;
         rdat = dat_o;
         {cyc, stb} <= 2'h0;
         @(posedge clk_i);
      end
   endtask
   task automatic wt(input integer k, input bit f);
      integer b, n;
      begin
         b = f ? fs_cnt : ls_cnt;
         n = 0;
         while ((f ? fs_cnt : ls_cnt) < b + k && n < 20000) begin
            @(posedge clk_i);
            n = n + 1;
         end
         if (n >= 20000)
            fails = fails + 1;
      end
   endtask
   task automatic cfg(input [2:0] m, input [1:0] t, input bit mm);
      begin
         wb(1'b1, `STN_ADR_CTRL, 32'h0000_0000);
         wb(1'b1, `STN_ADR_SIZE, {6'h00, 10'h002, 5'h00, 11'h003});
         wb(1'b1, `STN_ADR_TIME, {8'h00, 8'h02, 8'h01, 4'h0, 2'h1, 2'h1});
         wb(1'b1, `STN_ADR_CTRL, {6'h00, 10'h002, 9'h000, t, m, mm, 1'b1});
      end
   endtask
   // line: 4 clocks of 4 cycles, pulse 1, delay 1, blank 8
   task automatic run(input [2:0] m, input [1:0] t, input [15:0] f);
      begin
         cfg(m, t, 1'b0);
         wt(3, 1'b1);
         `CHK(first_dot, f)
         `CHK(shifts, 16'h0004)
         `CHK(lines, 16'h0003)
         `CHK(period, 16'h001A)
         `CHK(fs_len, 16'h001A)
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs;
      begin
         wb(1'b0, `STN_ADR_CTRL, 32'h0);
         `CHK(rdat, `STN_CTRL_RST)
         wb(1'b0, `STN_ADR_GREEN, 32'h0);
         `CHK(rdat, `STN_LUT_RST)
         wb(1'b1, `STN_ADR_RED, 32'h1234_5678);
         wb(1'b0, `STN_ADR_RED, 32'h0);
         `CHK(rdat, 32'h1234_5678)
         wb(1'b1, `STN_ADR_BLUE, 32'hFFFF_FFFF);
         wb(1'b0, `STN_ADR_BLUE, 32'h0);
         `CHK(rdat, 32'h0000_FFFF)
         wb(1'b1, 8'h1C, 32'hFFFF_FFFF);
         wb(1'b0, 8'h1C, 32'h0);
         `CHK(rdat, 32'h0000_0000)
         $display("test regs done");
      end
   endtask
   task automatic t_mono;
      begin
         up_d <= 32'hA5A5_A5A5;
         lo_d <= 32'h3C3C_3C3C;
         run(3'h0, 2'h0, 16'h00A3);
         run(3'h0, 2'h1, 16'h000A);
         run(3'h0, 2'h2, 16'h00A5);
         $display("test mono done");
      end
   endtask
   task automatic t_bias;
      integer b;
      begin
         cfg(3'h0, 2'h2, 1'b1);
         wt(1, 1'b0);
         b = flips;
         wt(12, 1'b0);
         `CHK(flips - b, 16'h0006)
         cfg(3'h0, 2'h2, 1'b0);
         wt(1, 1'b1);
         b = flips;
         wt(2, 1'b1);
         `CHK(flips - b, 16'h0002)
         $display("test bias done");
      end
   endtask
   // levels 0 and 15 only, so shading gives a fixed dot
   task automatic t_shade;
      begin
         up_d <= 32'h1B1B_1B1B;
         wb(1'b1, `STN_ADR_BLUE, 32'h0000_F0F0);
         run(3'h1, 2'h2, 16'h0055);
         wb(1'b1, `STN_ADR_BLUE, 32'h0000_FF00);
         run(3'h1, 2'h2, 16'h0033);
         up_d <= 32'hF0F0_F0F0;
         run(3'h2, 2'h2, 16'h00AA);
         up_d <= 32'h0F0F_0F0F;
         run(3'h4, 2'h2, 16'h0055);
         wb(1'b1, `STN_ADR_RED, 32'hF000_0000);
         wb(1'b1, `STN_ADR_GREEN, 32'hFFFF_FFF0);
         wb(1'b1, `STN_ADR_BLUE, 32'h0000_F000);
         up_d <= 32'hE3E3_E3E3;
         run(3'h3, 2'h2, 16'h00B6);
         $display("test shade done");
      end
   endtask
   task summarize;
      begin
         $display("checks %0d mismatches %0d", num_checks, fails);
         if (fails == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial begin
      {fails, num_checks} = 64'h0;
      {rst_i, cyc, stb, we, adr, wdat, up_d, lo_d} = {1'b1, 107'h0};
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs;
      t_mono;
      t_bias;
      t_shade;
      summarize;
   end
   initial begin
      repeat (60000) @(posedge clk_i);
      fails = fails + 1;
      summarize;
   end
endmodule // stn_lcd_timing_tb_top
